/* File: logic/msc_sideband_top.sv */
// Sideband control of a pluggable transceiver: select gating, reset handshake, low power,
// presence and attention. Core logic on MCLK, serial management on LINK_CLK.
// Assumes pad pull-ups resolve undriven select and reset pins to high before they arrive here.
`timescale 1ns/100ps

// Operation
// [RULE_01] Selected module answers management bus commands.
// [RULE_02] Deselected module ignores bus, never drives.
// [RULE_03] Undriven select reads as deselected.
// [RULE_04] Long reset pulse restores all user defaults.
// [RULE_05] Reset execution starts at reset rising edge.
// [RULE_06] Host ignores status until reset completes.
// [RULE_07] Completion shown by attention with not-ready cleared.
// [RULE_08] Power-up raises completion attention without reset.
// [RULE_09] Low-power request selects reduced power state.
// [RULE_10] Presence reads low while module inserted.
// [RULE_11] Attention driven low for faults, critical status.
// [RULE_12] Host reads status to find attention cause.
// [RULE_13] Bus device address is 1010000 plus direction.
// [RULE_14] Host reads flag field after attention.
// [RULE_15] Attention holds until flags read, then releases.
module msc_sideband_top import msc_pkg::*; #(
  parameter int unsigned     INIT_CYCLES = 32'(INIT_CYCLES_DEF),
  parameter logic [BYTE_W-1:0] IDENT_CODE = 8'hA5  // Arbitrary identifier value.
) (
  // Core clock and reset
  input  wire logic                  MCLK,
  input  wire logic                  RESET,
  // Link clock
  input  wire logic                  LINK_CLK,
  // Host sideband pins
  input  wire logic                  MODULE_SELECT_PIN_N,
  input  wire logic                  MODULE_RESET_N,
  input  wire logic                  LOW_POWER_REQUEST,
  output logic                       PRESENCE_N,
  output logic                       ATTENTION_N_O,
  output logic                       ATTENTION_N_OE,
  // Management bus pins
  input  wire logic                  SCL,
  input  wire logic                  SDA_I,
  output logic                       SDA_O,
  output logic                       SDA_OE,
  // On-chip monitors, MCLK domain
  input  wire logic [NUM_FAULTS-1:0] FAULT_EVENT,
  output logic                       LOW_POWER_EN
);
  // ==========================================================================
  // Core domain declarations
  // ==========================================================================
  msc_rst_state_type rst_state_reg, rst_state_next;
  logic [31:0]       init_cnt_reg, init_cnt_next;
  logic [31:0]       hold_cnt_reg, hold_cnt_next;
  logic              dnr_reg, dnr_next;
  logic [BYTE_W-1:0] flags_reg, flags_next;
  logic              settings_clear_reg;
  logic              attn_reg;
  logic              attn_o_reg;
  logic              low_power_reg;
  logic              presence_n_reg;
  logic              clr_seen_reg;
  logic              rst_pin_s, lp_pin_s, soft_lp_s, clr_tog_s;

  // ==========================================================================
  // Link domain declarations
  // ==========================================================================
  logic              link_rst_meta_reg, link_rst_reg;
  logic              select_n_s, scl_s, sda_s;
  logic              dnr_s, settings_clear_s;
  logic [BYTE_W-1:0] flags_s;
  logic [BYTE_W-1:0] control_reg;
  logic              flag_rd_tog_reg;
  logic              sda_o_reg;
  logic              twi_oe;
  msc_link_if        link_if ();

  // ==========================================================================
  // Crossings
  // ==========================================================================
  msc_sync #(.WIDTH(2), .RESET_VAL({PIN_IDLE, 1'b0})) u_pin_sync (
    .clk (MCLK),
    .rst (RESET),
    .d   ({MODULE_RESET_N, LOW_POWER_REQUEST}),
    .q   ({rst_pin_s, lp_pin_s})
  );
  msc_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_core_sync (
    .clk (MCLK),
    .rst (RESET),
    .d   ({control_reg[CTRL_LP_BIT], flag_rd_tog_reg}),
    .q   ({soft_lp_s, clr_tog_s})
  );
  msc_sync #(.WIDTH(3), .RESET_VAL({PIN_IDLE, PIN_IDLE, PIN_IDLE})) u_link_pin_sync (
    .clk (LINK_CLK),
    .rst (link_rst_reg),
    .d   ({MODULE_SELECT_PIN_N, SCL, SDA_I}),
    .q   ({select_n_s, scl_s, sda_s}) // RULE_03
  );
  msc_sync #(.WIDTH(BYTE_W + 2), .RESET_VAL({DNR_RESET, DNR_RESET, BYTE_ZERO})) u_status_sync (
    .clk (LINK_CLK),
    .rst (link_rst_reg),
    .d   ({settings_clear_reg, dnr_reg, flags_reg}),
    .q   ({settings_clear_s, dnr_s, flags_s})
  );

  // ==========================================================================
  // Reset sequencer
  // ==========================================================================
  wire in_init   = (rst_state_reg == RS_INIT);
  wire init_end  = in_init && rst_pin_s && (init_cnt_reg == 32'(INIT_CYCLES - 1));
  wire hold_long = (hold_cnt_reg >= 32'(RESET_MIN_CYCLES));
  wire clr_pulse = clr_tog_s ^ clr_seen_reg;
  wire [BYTE_W-1:0] flag_set = BYTE_W'(FAULT_EVENT) | (init_end ? FLAG_DONE_MASK : BYTE_ZERO);

  always_comb begin
    rst_state_next = rst_state_reg;
    init_cnt_next  = init_cnt_reg;
    hold_cnt_next  = hold_cnt_reg;
    dnr_next       = dnr_reg;
    unique case (rst_state_reg)
      RS_INIT: begin
        init_cnt_next = init_cnt_reg + 32'h1;
        if (!rst_pin_s) begin
          rst_state_next = RS_HOLD;
          hold_cnt_next  = 32'h0;
        end else if (init_end) begin
          rst_state_next = RS_RUN; // RULE_08
          dnr_next       = 1'b0; // RULE_07
        end
      end
      RS_RUN: begin
        if (!rst_pin_s) begin
          rst_state_next = RS_HOLD;
          hold_cnt_next  = 32'h0;
        end
      end
      RS_HOLD: begin
        if (rst_pin_s) begin
          // A short glitch is ignored unless an initialisation was already pending.
          rst_state_next = (hold_long || dnr_reg) ? RS_INIT : RS_RUN; // RULE_04 RULE_05
          init_cnt_next  = 32'h0;
          dnr_next       = dnr_reg | hold_long;
        end else if (!hold_long) begin
          hold_cnt_next = hold_cnt_reg + 32'h1;
        end
      end
      default: begin
        rst_state_next = RS_INIT;
        init_cnt_next  = 32'h0;
        dnr_next       = DNR_RESET;
      end
    endcase
  end

  // Flags are sticky outside initialisation; a fault in the cycle of a clear-on-read survives the clear.
  always_comb begin
    if (in_init) begin
      flags_next = init_end ? FLAG_DONE_MASK : BYTE_ZERO; // RULE_04 RULE_08
    end else begin
      flags_next = (clr_pulse ? BYTE_ZERO : flags_reg) | flag_set; // RULE_11 RULE_15
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      rst_state_reg      <= RS_INIT;
      init_cnt_reg       <= 32'h0;
      hold_cnt_reg       <= 32'h0;
      dnr_reg            <= DNR_RESET;
      flags_reg          <= BYTE_ZERO;
      settings_clear_reg <= DNR_RESET;
      attn_reg           <= 1'b0;
      attn_o_reg         <= 1'b0;
      low_power_reg      <= 1'b0;
      presence_n_reg     <= 1'b0;
      clr_seen_reg       <= 1'b0;
    end else begin
      rst_state_reg      <= rst_state_next;
      init_cnt_reg       <= init_cnt_next;
      hold_cnt_reg       <= hold_cnt_next;
      dnr_reg            <= dnr_next;
      flags_reg          <= flags_next;
      settings_clear_reg <= (rst_state_next == RS_INIT); // RULE_04
      attn_reg           <= (|flags_reg) && !in_init; // RULE_07 RULE_11 RULE_15
      attn_o_reg         <= 1'b0; // RULE_11
      low_power_reg      <= lp_pin_s | soft_lp_s; // RULE_09
      presence_n_reg     <= 1'b0; // RULE_10
      clr_seen_reg       <= clr_tog_s;
    end
  end

  assign PRESENCE_N     = presence_n_reg;
  // Open-drain data stays at the low level; the enable alone decides the pin level.
  assign ATTENTION_N_O  = attn_o_reg;
  assign ATTENTION_N_OE = attn_reg;
  assign LOW_POWER_EN   = low_power_reg;

  // ==========================================================================
  // Link domain: reset, byte store, serial slave
  // ==========================================================================
  always_ff @(posedge LINK_CLK) begin
    link_rst_meta_reg <= RESET;
    link_rst_reg      <= link_rst_meta_reg;
  end

  wire ctrl_wr  = link_if.wr_en && (link_if.addr == REG_CONTROL);
  wire flags_rd = link_if.rd_en && (link_if.addr == REG_FLAGS);
  wire [BYTE_W-1:0] status_byte = BYTE_W'(dnr_s) << STATUS_DNR_BIT; // RULE_06
  assign link_if.rd_data = (link_if.addr == REG_IDENT)   ? IDENT_CODE  :
                           (link_if.addr == REG_STATUS)  ? status_byte :
                           (link_if.addr == REG_FLAGS)   ? flags_s     : // RULE_12 RULE_14
                           (link_if.addr == REG_CONTROL) ? control_reg : BYTE_ZERO;

  always_ff @(posedge LINK_CLK) begin
    if (link_rst_reg || settings_clear_s) begin
      control_reg <= CONTROL_RESET; // RULE_04
    end else if (ctrl_wr) begin
      control_reg <= link_if.wr_data;
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (link_rst_reg) begin
      flag_rd_tog_reg <= 1'b0;
      sda_o_reg       <= 1'b0;
    end else begin
      flag_rd_tog_reg <= flag_rd_tog_reg ^ flags_rd; // RULE_15
      sda_o_reg       <= 1'b0;
    end
  end

  msc_twi_slave u_twi (
    .clk      (LINK_CLK),
    .rst      (link_rst_reg),
    .scl      (scl_s),
    .sda      (sda_s),
    .select_n (select_n_s),
    .sda_oe   (twi_oe),
    .bus      (link_if.slave)
  );

  assign SDA_O  = sda_o_reg;
  assign SDA_OE = twi_oe; // RULE_02

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_full_reset: assert property (@(posedge MCLK) disable iff (RESET) // RULE_04
    (rst_state_reg == RS_HOLD && rst_pin_s && hold_long) |=> (in_init && dnr_reg ##1 settings_clear_reg))
    else $error("long reset pulse did not start a full reset");
  a_glitch_ignored: assert property (@(posedge MCLK) disable iff (RESET) // RULE_04
    (rst_state_reg == RS_HOLD && rst_pin_s && !hold_long && !dnr_reg) |=> (rst_state_reg == RS_RUN))
    else $error("short reset pulse was not ignored");
  a_init_on_rise: assert property (@(posedge MCLK) disable iff (RESET) // RULE_05
    $rose(in_init) |-> ($past(rst_pin_s) && $past(rst_state_reg == RS_HOLD)))
    else $error("reset execution began without a reset release");
  a_done_attention: assert property (@(posedge MCLK) disable iff (RESET) // RULE_07
    $fell(dnr_reg) |-> ((flags_reg & FLAG_DONE_MASK) != BYTE_ZERO) ##1 attn_reg)
    else $error("completion not signalled by attention");
  a_powerup_done: assert property (@(posedge MCLK) disable iff (RESET) // RULE_08
    init_end |=> (!dnr_reg && rst_state_reg == RS_RUN && flags_reg[7]))
    else $error("initialisation end did not post completion");
  a_low_power: assert property (@(posedge MCLK) disable iff (RESET) // RULE_09
    lp_pin_s |=> LOW_POWER_EN)
    else $error("low power request not honoured");
  a_presence_low: assert property (@(posedge MCLK) disable iff (RESET) // RULE_10
    !PRESENCE_N)
    else $error("presence not indicated");
  a_fault_attention: assert property (@(posedge MCLK) disable iff (RESET) // RULE_11
    ((|FAULT_EVENT) && rst_state_reg == RS_RUN) |-> ##2 ATTENTION_N_OE)
    else $error("fault did not raise attention");
  // Attention follows the flags one cycle late, so the cycle after a clear is exempt.
  a_attention_hold: assert property (@(posedge MCLK) disable iff (RESET) // RULE_15
    (attn_reg && !clr_pulse && !$past(clr_pulse) && rst_state_reg == RS_RUN) |=> attn_reg)
    else $error("attention released before flags were read");
  a_attention_release: assert property (@(posedge MCLK) disable iff (RESET) // RULE_15
    (clr_pulse && FAULT_EVENT == '0 && rst_state_reg == RS_RUN) |-> ##2 !attn_reg)
    else $error("attention not released after flag read");
  a_settings_default: assert property (@(posedge LINK_CLK) disable iff (link_rst_reg) // RULE_04
    settings_clear_s |=> (control_reg == CONTROL_RESET))
    else $error("user settings not restored");
  a_attention_drive: assert property (@(posedge MCLK) disable iff (RESET) // RULE_11
    !ATTENTION_N_O)
    else $error("attention data not at the driven-low level");
  a_soft_low_power: assert property (@(posedge MCLK) disable iff (RESET) // RULE_09
    soft_lp_s |=> LOW_POWER_EN)
    else $error("soft low power not honoured");
  a_full_power: assert property (@(posedge MCLK) disable iff (RESET) // RULE_09
    (!lp_pin_s && !soft_lp_s) |=> !LOW_POWER_EN)
    else $error("low power held without a request");
  a_flags_sticky: assert property (@(posedge MCLK) disable iff (RESET) // RULE_15
    (!clr_pulse && !in_init) |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
    else $error("flag lost without a read");
  a_run_ready: assert property (@(posedge MCLK) disable iff (RESET) // RULE_07
    (rst_state_reg == RS_RUN) |-> !dnr_reg)
    else $error("running with not-ready still set");
  // Link-domain check at the data pin enable itself.
  a_pin_deselect: assert property (@(posedge LINK_CLK) disable iff (link_rst_reg) // RULE_02
    select_n_s |=> !SDA_OE)
    else $error("data line driven while deselected");

  c_full_reset: cover property (@(posedge MCLK) disable iff (RESET) $rose(in_init));
  c_glitch: cover property (@(posedge MCLK) disable iff (RESET)
    rst_state_reg == RS_HOLD && rst_pin_s && !hold_long);
  c_attention: cover property (@(posedge MCLK) disable iff (RESET) $fell(attn_reg));
endmodule : msc_sideband_top

/* File: logic/msc_pkg.sv */
// Constants, state encodings and timing figures shared by the sideband control block.
// Assumes a 20 MHz core clock; every cycle count below is derived from that rate.
package msc_pkg;

  // ==========================================================================
  // Management bus
  // ==========================================================================
  localparam int           BYTE_W         = 8;
  localparam logic [6:0]   TWI_DEV_ADDR   = 7'h50;
  localparam logic [3:0]   BYTE_BITS      = 4'h8;
  localparam logic [7:0]   REG_IDENT      = 8'h00;
  localparam logic [7:0]   REG_STATUS     = 8'h02;
  localparam logic [7:0]   REG_FLAGS      = 8'h03;
  localparam logic [7:0]   REG_CONTROL    = 8'h56;
  localparam logic [7:0]   CONTROL_RESET  = 8'h00;
  localparam logic [7:0]   BYTE_ZERO      = 8'h00;
  localparam int           CTRL_LP_BIT    = 0;
  localparam int           STATUS_DNR_BIT = 0;

  // ==========================================================================
  // Flags and pins
  // ==========================================================================
  localparam int           NUM_FAULTS     = 4;
  localparam logic [7:0]   FLAG_DONE_MASK = 8'h80;
  localparam logic         PIN_IDLE       = 1'b1;
  localparam logic         DNR_RESET      = 1'b1;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned     CLK_PERIOD_NS    = 50;
  localparam int unsigned     T_RESET_MIN_NS   = 10000;
  localparam int unsigned     RESET_MIN_CYCLES = (T_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned     T_INIT_MS        = 2000;
  localparam longint unsigned INIT_CYCLES_DEF  = (64'(T_INIT_MS) * 64'd1000000) / 64'(CLK_PERIOD_NS);

  // ==========================================================================
  // State encodings
  // ==========================================================================
  typedef enum logic [1:0] {
    RS_INIT = 2'h0,
    RS_RUN  = 2'h1,
    RS_HOLD = 2'h2
  } msc_rst_state_type;

  typedef enum logic [3:0] {
    TW_IDLE = 4'h0,
    TW_ADDR = 4'h1,
    TW_ACKA = 4'h2,
    TW_PTR  = 4'h3,
    TW_ACKP = 4'h4,
    TW_WDAT = 4'h5,
    TW_ACKW = 4'h6,
    TW_RDAT = 4'h7,
    TW_RACK = 4'h8
  } msc_twi_state_type;

endpackage : msc_pkg

/* File: logic/msc_link_if.sv */
// Byte access path between the serial slave and the management byte store.
// Both ends run on the link clock.
`timescale 1ns/100ps
interface msc_link_if import msc_pkg::*; ();
  logic [BYTE_W-1:0] addr;
  logic              wr_en;
  logic [BYTE_W-1:0] wr_data;
  logic              rd_en;
  logic [BYTE_W-1:0] rd_data;

  modport slave (output addr, output wr_en, output wr_data, output rd_en, input rd_data);
  modport regs  (input addr, input wr_en, input wr_data, input rd_en, output rd_data);
endinterface : msc_link_if

/* File: logic/msc_sync.sv */
// Two-stage level synchroniser with a constant reset value.
// Assumes the reset is synchronous to the destination clock.
`timescale 1ns/100ps
module msc_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Destination domain
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule : msc_sync

/* File: logic/msc_twi_slave.sv */
// Two-wire management slave, oversampling synchronised clock and data on the link clock.
// Assumes scl, sda and select_n are already synchronised; sda is driven open-drain via sda_oe.
`timescale 1ns/100ps
module msc_twi_slave import msc_pkg::*; (
  // Link clock domain
  input  wire logic   clk,
  input  wire logic   rst,
  // Synchronised pins
  input  wire logic   scl,
  input  wire logic   sda,
  input  wire logic   select_n,
  output logic        sda_oe,
  // Byte store
  msc_link_if.slave   bus
);
  msc_twi_state_type state_reg, state_next;
  logic              scl_prev_reg, sda_prev_reg;
  logic [BYTE_W-1:0] shreg_reg, shreg_next;
  logic [3:0]        cnt_reg, cnt_next;
  logic              rw_reg, rw_next;
  logic [BYTE_W-1:0] ptr_reg, ptr_next;
  logic              oe_reg, oe_next;
  logic              wr_en_reg, wr_en_next;
  logic              rd_en_reg, rd_en_next;

  wire scl_rise   = scl & ~scl_prev_reg;
  wire scl_fall   = ~scl & scl_prev_reg;
  wire start_cond = scl & scl_prev_reg & sda_prev_reg & ~sda;
  wire stop_cond  = scl & scl_prev_reg & ~sda_prev_reg & sda;
  wire byte_done  = (cnt_reg == BYTE_BITS);
  wire addr_hit   = (shreg_reg[7:1] == TWI_DEV_ADDR);
  wire [BYTE_W-1:0] shift_in = {shreg_reg[6:0], sda};

  // ==========================================================================
  // Protocol sequencer
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    shreg_next = shreg_reg;
    cnt_next   = cnt_reg;
    rw_next    = rw_reg;
    ptr_next   = ptr_reg;
    oe_next    = oe_reg;
    wr_en_next = 1'b0;
    rd_en_next = 1'b0;
    if (select_n) begin
      state_next = TW_IDLE; // RULE_02
      oe_next    = 1'b0; // RULE_02
    end else if (start_cond) begin
      state_next = TW_ADDR; // RULE_01
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
    end else if (stop_cond) begin
      state_next = TW_IDLE;
      oe_next    = 1'b0;
    end else begin
      unique case (state_reg)
        TW_IDLE: begin
        end
        TW_ADDR, TW_PTR, TW_WDAT: begin
          if (scl_rise) begin
            shreg_next = shift_in;
            cnt_next   = cnt_reg + 4'h1;
          end else if (scl_fall && byte_done) begin
            oe_next = 1'b1;
            if (state_reg == TW_ADDR) begin
              state_next = addr_hit ? TW_ACKA : TW_IDLE; // RULE_13
              oe_next    = addr_hit;
              rw_next    = shreg_reg[0];
            end else if (state_reg == TW_PTR) begin
              ptr_next   = shreg_reg;
              state_next = TW_ACKP;
            end else begin
              wr_en_next = 1'b1;
              state_next = TW_ACKW;
            end
          end
        end
        TW_ACKA, TW_ACKP, TW_ACKW, TW_RACK: begin
          if (state_reg == TW_RACK && scl_rise && sda) begin
            state_next = TW_IDLE;
          end else if (scl_fall) begin
            cnt_next = 4'h0;
            if ((state_reg == TW_ACKA && rw_reg) || state_reg == TW_RACK) begin
              state_next = TW_RDAT; // RULE_01
              shreg_next = bus.rd_data;
              oe_next    = ~bus.rd_data[7];
              rd_en_next = 1'b1;
            end else begin
              state_next = (state_reg == TW_ACKA) ? TW_PTR : TW_WDAT;
              oe_next    = 1'b0;
              if (state_reg == TW_ACKW) begin
                ptr_next = ptr_reg + 8'h01;
              end
            end
          end
        end
        TW_RDAT: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (byte_done) begin
              state_next = TW_RACK;
              oe_next    = 1'b0;
              ptr_next   = ptr_reg + 8'h01;
            end else begin
              shreg_next = {shreg_reg[6:0], 1'b0};
              oe_next    = ~shreg_reg[6];
            end
          end
        end
        default: begin
          state_next = TW_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= TW_IDLE;
      scl_prev_reg <= PIN_IDLE;
      sda_prev_reg <= PIN_IDLE;
      shreg_reg    <= BYTE_ZERO;
      cnt_reg      <= 4'h0;
      rw_reg       <= 1'b0;
      ptr_reg      <= BYTE_ZERO;
      oe_reg       <= 1'b0;
      wr_en_reg    <= 1'b0;
      rd_en_reg    <= 1'b0;
    end else begin
      state_reg    <= state_next;
      scl_prev_reg <= scl;
      sda_prev_reg <= sda;
      shreg_reg    <= shreg_next;
      cnt_reg      <= cnt_next;
      rw_reg       <= rw_next;
      ptr_reg      <= ptr_next;
      oe_reg       <= oe_next;
      wr_en_reg    <= wr_en_next;
      rd_en_reg    <= rd_en_next;
    end
  end

  assign sda_oe      = oe_reg;
  assign bus.addr    = ptr_reg;
  assign bus.wr_en   = wr_en_reg;
  assign bus.wr_data = shreg_reg;
  assign bus.rd_en   = rd_en_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_deselect_quiet: assert property (@(posedge clk) disable iff (rst) // RULE_02
    select_n |=> (!oe_reg && state_reg == TW_IDLE))
    else $error("slave still active while deselected");
  a_ack_selected: assert property (@(posedge clk) disable iff (rst) // RULE_01
    $rose(state_reg == TW_ACKA) |-> ($past(!select_n) && oe_reg))
    else $error("address acknowledge without select or without drive");
  a_ack_address: assert property (@(posedge clk) disable iff (rst) // RULE_13
    $rose(state_reg == TW_ACKA) |-> ($past(shreg_reg[7:1]) == TWI_DEV_ADDR))
    else $error("acknowledged a foreign device address");
  c_read_byte: cover property (@(posedge clk) disable iff (rst) $rose(state_reg == TW_RACK));
  c_write_byte: cover property (@(posedge clk) disable iff (rst) wr_en_reg);
endmodule : msc_twi_slave

/* File: sim/msc_host_model.sv */
// Host controller model: masters the 2-wire bus.
// Assumes a pull-up on the data wire.
`timescale 1ns/100ps
module msc_host_model (
  // Bus wires
  input  wire logic slave_oe,
  input  wire logic slave_o,
  output logic      scl,
  output logic      sda
);
  // ==========
  // Bus tasks
  logic host_oe = 1'b0;
  initial scl = 1'b1;
  assign sda = ~host_oe & (slave_oe ? slave_o : 1'b1);
  task automatic bt(input logic b, output logic v);
    #500 host_oe = ~b;
    #500 scl = 1'b1;
    v = sda;
    #500 scl = 1'b0;
  endtask : bt
  task automatic by(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) bt(d[i], q[i]);
  endtask : by
  task automatic st;
    #500 host_oe = 1'b0;
    #500 scl = 1'b1;
    #500 host_oe = 1'b1;
    #500 scl = 1'b0;
  endtask : st
  task automatic sp;
    #500 host_oe = 1'b1;
    #500 scl = 1'b1;
    #500 host_oe = 1'b0;
  endtask : sp
  // Write sends one byte; read re-addresses and ends the byte with a NACK.
  task automatic xfer(input logic [7:0] dv, pt, wd, output logic [7:0] rd, output logic nak);
    logic [8:0] q0, q1, q2;
    st();
    by({dv & 8'hFE, 1'b1}, q0);
    by({pt, 1'b1}, q1);
    if (dv[0]) begin
      st();
      by({dv, 1'b1}, q2);
      nak = q0[0] | q1[0] | q2[0];
      by(9'h1FF, q2);
    end else begin
      by({wd, 1'b1}, q2);
      nak = q0[0] | q1[0] | q2[0];
    end
    rd = q2[8:1];
    sp();
  endtask : xfer
endmodule : msc_host_model

/* File: sim/tb_msc_sideband_top.sv */
// Bench of the sideband top: bus access, reset handshake, faults, low power.
// Assumes msc_host_model as bus master.
`timescale 1ns/100ps
module tb_msc_sideband_top import msc_pkg::*; ;
  // ==========
  // Design and host
  logic        mclk = 1'b0, lclk = 1'b0, rst = 1'b1, sel_n = 1'b1, mrst_n = 1'b1, lpr = 1'b0;
  logic [3:0]  fault = 4'h0;
  logic        prs_n, att_oe, att_o, scl, sda, sda_oe, sda_o, lpe, nak;
  logic [7:0]  rd;
  int          err_total = 0, comparisons = 0;
  logic [31:0] rows [7] = '{32'hA10000A5, 32'hA0560100, 32'hA1560001, 32'hA1100000,
                            32'hA0005A00, 32'hA10000A5, 32'hA30000FF};
  always #25 mclk = ~mclk;
  always #15 lclk = ~lclk;
  msc_sideband_top #(.INIT_CYCLES(50)) i_msc_sideband_top (
    .MCLK(mclk), .RESET(rst), .LINK_CLK(lclk), .MODULE_SELECT_PIN_N(sel_n), .MODULE_RESET_N(mrst_n),
    .LOW_POWER_REQUEST(lpr), .PRESENCE_N(prs_n), .ATTENTION_N_O(att_o), .ATTENTION_N_OE(att_oe),
    .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .FAULT_EVENT(fault), .LOW_POWER_EN(lpe));
  msc_host_model i_msc_host_model (.slave_oe(sda_oe), .slave_o(sda_o), .scl(scl), .sda(sda));
  // ==========
  // Checks
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic wait_att(input logic exp);
    int n;
    for (n = 0; n < 500 && att_oe !== exp; n++) @(negedge mclk);
    check("attention", 8'(att_oe), 8'(exp));
    check("attention pin", 8'(att_oe ? att_o : 1'b1), 8'(!exp));
    if (n == 500) wrap_up();
  endtask : wait_att
  // Row: device byte, pointer, write data, expected read data.
  task automatic op(input logic [31:0] r);
    i_msc_host_model.xfer(r[31:24], r[23:16], r[15:8], rd, nak);
    check("nack", 8'(nak), 8'((r[31:25] != TWI_DEV_ADDR) | sel_n));
    if (r[24]) check("read data", rd, r[7:0]);
  endtask : op
  // ==========
  // Sequence
  initial begin
    repeat (8) @(negedge mclk);
    check("presence", 8'(prs_n), 8'h00);
    check("attention", 8'(att_oe), 8'h00);
    rst = 1'b0;
    wait_att(1'b1);
    @(negedge mclk) sel_n = 1'b0;
    op(32'hA1020000);
    op(32'hA1030080);
    wait_att(1'b0);
    foreach (rows[i]) op(rows[i]);
    check("low power", 8'(lpe), 8'h01);
    @(negedge mclk) sel_n = 1'b1;
    op(32'hA10000FF);
    @(negedge mclk) sel_n = 1'b0;
    fault = 4'h4;
    @(negedge mclk) fault = 4'h0;
    wait_att(1'b1);
    op(32'hA1030004);
    wait_att(1'b0);
    @(negedge mclk) mrst_n = 1'b0;
    repeat (220) @(negedge mclk);
    mrst_n = 1'b1;
    wait_att(1'b1);
    op(32'hA1560000);
    check("low power", 8'(lpe), 8'h00);
    @(negedge mclk) lpr = 1'b1;
    repeat (6) @(negedge mclk);
    check("low power", 8'(lpe), 8'h01);
    @(negedge mclk) mrst_n = 1'b0;
    repeat (20) @(negedge mclk);
    mrst_n = 1'b1;
    repeat (10) @(negedge mclk);
    check("attention", 8'(att_oe), 8'h01);
    wrap_up();
  end
endmodule : tb_msc_sideband_top
